// ### common/crd_map.vh
// Constants for the cpu register datapath block.
// Included by the design file; holds definitions only.
`ifndef CRD_MAP_VH
`define CRD_MAP_VH
// ----------------------------------------
// Register byte offsets (low address byte)
// ----------------------------------------
`define CRD_OFF_CTRL    8'h00
`define CRD_OFF_MODE    8'h04
`define CRD_OFF_PC      8'h08
`define CRD_OFF_ACC     8'h0C
`define CRD_OFF_IDX_X   8'h10
`define CRD_OFF_IDX_Y   8'h14
`define CRD_OFF_DBANK   8'h18
`define CRD_OFF_DIRECT  8'h1C
`define CRD_OFF_FLAGS   8'h20
`define CRD_OFF_OPSTAT  8'h24
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CRD_CTRL_START   0
`define CRD_CTRL_ABORTED 1
`define CRD_MODE_E       0
`define CRD_MODE_M       1
`define CRD_MODE_X       2
// ----------------------------------------
// Operation field, opcode bits 7:5
// ----------------------------------------
`define CRD_OP_LDA 3'h0
`define CRD_OP_STA 3'h1
`define CRD_OP_ADC 3'h2
`define CRD_OP_AND 3'h3
`define CRD_OP_LDX 3'h4
`define CRD_OP_LDY 3'h5
`define CRD_OP_SWP 3'h6
`define CRD_OP_NOP 3'h7
// ----------------------------------------
// Addressing field, opcode bits 2:0
// ----------------------------------------
`define CRD_AM_IMM   3'h0
`define CRD_AM_DIR   3'h1
`define CRD_AM_ABS   3'h2
`define CRD_AM_ABSX  3'h3
`define CRD_AM_ABSY  3'h4
`define CRD_AM_DIRXI 3'h5
`define CRD_AM_DIRIY 3'h6
`define CRD_AM_VEC   3'h7
// ----------------------------------------
// Vector location and reset values
// ----------------------------------------
`define CRD_VEC_ADDR 16'hFFF0
`define CRD_RST_MODE 3'h7
`endif

// ### rtl/crd_core.v
// Register section and cycle control of an 8/16-bit processor core,
// programmed and inspected over an AHB-Lite slave port.
// Assumes one external memory on a multiplexed bank/data bus that
// answers every cycle; the testbench resolves the data wire.
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "crd_map.vh"

module crd_core (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  // External memory bus
  output reg  [15:0] mem_addr,
  output reg  [7:0]  mem_data_out,
  output reg         mem_data_oe,
  input  wire [7:0]  mem_data_in,
  output reg         mem_rwb,
  output reg         valid_data_addr_out,
  output reg         valid_program_addr_out,
  output reg         vector_pull_out_n,
  input  wire        abort_input_n,
  output wire        emulation_out
);

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_FETCH = 3'h1;
  localparam [2:0] S_OPL   = 3'h2;
  localparam [2:0] S_OPH   = 3'h3;
  localparam [2:0] S_PTRL  = 3'h4;
  localparam [2:0] S_PTRH  = 3'h5;
  localparam [2:0] S_DAT   = 3'h6;
  localparam [2:0] S_EXEC  = 3'h7;

  reg [2:0]  st_r;
  reg        ph_r, bidx_r;
  reg [3:0]  step_r;
  reg [7:0]  opcode_latch_r, pbr_r, data_bank_reg_r;
  reg [15:0] pc_r, pc_start_r;
  reg [15:0] acc_r, x_r, y_r;
  reg [15:0] direct_r;
  reg        emu_r, msel_r, xsel_r;
  reg        fc_r, fz_r, fv_r, fn_r;
  reg [15:0] ea_r, ptr_r, opnd_r;
  reg [7:0]  bank_r, opl_r, wa_r;
  reg        abt_r, aborted_r, wr_pend_r;
  reg [31:0] hrdata_r, rd_mux;

  // ----------------------------------------
  // Width decode
  // ----------------------------------------
  wire [2:0]  op     = opcode_latch_r[7:5];
  wire [2:0]  am     = opcode_latch_r[2:0];
  wire        m_eff  = emu_r | msel_r;
  wire        x_eff  = emu_r | xsel_r;
  wire        ld_idx = (op == `CRD_OP_LDX) || (op == `CRD_OP_LDY);
  wire        wide   = ld_idx ? ~x_eff : ~m_eff;
  wire [15:0] xv     = x_eff ? {8'h00, x_r[7:0]} : x_r;
  wire [15:0] yv     = x_eff ? {8'h00, y_r[7:0]} : y_r;
  wire        busy   = (st_r != S_IDLE);
  wire        cyc_end = busy && (st_r != S_EXEC) && ph_r;
  wire        is_wr  = (st_r == S_DAT) && (op == `CRD_OP_STA);
  // Direct sum of the operand byte on the bus, wraps in bank zero
  wire [15:0] dsum   = direct_r + {8'h00, mem_data_in};
  assign emulation_out = emu_r;

  // ----------------------------------------
  // ALU: 16 bits, 8-bit ADC and AND results keep the high byte
  // ----------------------------------------
  reg [16:0] sum17;
  reg [8:0]  sum9;
  reg [15:0] res;
  reg        res_c, res_v, res_n, res_z;
  always @* begin
    sum17 = {1'b0, acc_r} + {1'b0, opnd_r} + {16'h0000, fc_r};
    sum9  = {1'b0, acc_r[7:0]} + {1'b0, opnd_r[7:0]} + {8'h00, fc_r};
    res_c = fc_r;
    res_v = fv_r;
    case (op)
      `CRD_OP_ADC: begin
        res   = wide ? sum17[15:0] : {acc_r[15:8], sum9[7:0]};
        res_c = wide ? sum17[16] : sum9[8];
        res_v = wide ? ((acc_r[15] ^ res[15]) & (opnd_r[15] ^ res[15]))
                     : ((acc_r[7] ^ res[7]) & (opnd_r[7] ^ res[7]));
      end
      `CRD_OP_AND: res = wide ? (acc_r & opnd_r)
                              : {acc_r[15:8], acc_r[7:0] & opnd_r[7:0]};
      `CRD_OP_SWP: res = {acc_r[7:0], acc_r[15:8]};
      default:     res = opnd_r;
    endcase
    // Swap always reports on the new low byte
    res_n = (wide && op != `CRD_OP_SWP) ? res[15] : res[7];
    res_z = (wide && op != `CRD_OP_SWP) ? (res == 16'h0000)
                                         : (res[7:0] == 8'h00);
  end

  // ----------------------------------------
  // External bus drive, decoded from state
  // ----------------------------------------
  always @* begin
    mem_addr               = 16'h0000;
    mem_data_out           = 8'h00;
    mem_data_oe            = 1'b0;
    mem_rwb                = 1'b1;
    valid_data_addr_out    = 1'b0;
    valid_program_addr_out = 1'b0;
    vector_pull_out_n      = 1'b1;
    case (st_r)
      S_FETCH, S_OPL, S_OPH: begin
        mem_addr               = pc_r;
        valid_program_addr_out = 1'b1;
      end
      S_PTRL, S_PTRH: begin
        mem_addr            = ptr_r;
        valid_data_addr_out = 1'b1;
      end
      S_DAT: begin
        if (am == `CRD_AM_IMM) begin
          mem_addr               = pc_r;
          valid_program_addr_out = 1'b1;
        end else begin
          mem_addr            = ea_r + {15'h0000, bidx_r};
          valid_data_addr_out = 1'b1;
          vector_pull_out_n   = (am != `CRD_AM_VEC);
        end
        mem_rwb = ~is_wr;
      end
      default: mem_addr = 16'h0000;
    endcase
    // Bank byte first half, write data second half
    if (busy && st_r != S_EXEC) begin
      if (!ph_r) begin
        mem_data_oe  = 1'b1;
        mem_data_out = (st_r == S_PTRL || st_r == S_PTRH) ? 8'h00 :
                       ((st_r == S_DAT && am != `CRD_AM_IMM) ? bank_r
                                                              : pbr_r);
      end else if (is_wr) begin
        mem_data_oe  = 1'b1;
        mem_data_out = bidx_r ? acc_r[15:8] : acc_r[7:0];
      end
    end
  end

  // ----------------------------------------
  // AHB-Lite slave: zero wait, always OKAY
  // ----------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  wire acc_ph = hsel & htrans[1] & hready;
  // Read data picked up in the address phase so it is a flop output
  always @* begin
    case (haddr[7:0])
      `CRD_OFF_CTRL:   rd_mux = {30'h0, aborted_r, busy};
      `CRD_OFF_MODE:   rd_mux = {29'h0, x_eff, m_eff, emu_r};
      `CRD_OFF_PC:     rd_mux = {8'h00, pbr_r, pc_r};
      `CRD_OFF_ACC:    rd_mux = {16'h0000, acc_r};
      `CRD_OFF_IDX_X:  rd_mux = {16'h0000, xv};
      `CRD_OFF_IDX_Y:  rd_mux = {16'h0000, yv};
      `CRD_OFF_DBANK:  rd_mux = {24'h000000, data_bank_reg_r};
      `CRD_OFF_DIRECT: rd_mux = {16'h0000, direct_r};
      `CRD_OFF_FLAGS:  rd_mux = {28'h0, fn_r, fv_r, fz_r, fc_r};
      `CRD_OFF_OPSTAT: rd_mux = {20'h0, step_r, opcode_latch_r};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  wire sw_wr    = wr_pend_r && !busy;
  wire ctrl_wr  = wr_pend_r && (wa_r == `CRD_OFF_CTRL);
  wire go       = sw_wr && ctrl_wr && hwdata[`CRD_CTRL_START];
  wire abort_ev = busy && !abort_input_n;

  // ----------------------------------------
  // Registers and sequencer
  // ----------------------------------------
  // Software writes other than the aborted clear land only while idle, so they never race a commit.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r                          <= S_IDLE;
      {ph_r, bidx_r}                <= 2'h0;
      step_r                        <= 4'h0;
      opcode_latch_r                <= 8'h00;
      {pc_r, pc_start_r}            <= 32'h00000000;
      pbr_r                         <= 8'h00;
      acc_r                         <= 16'h0000;
      {x_r, y_r}                    <= 32'h00000000;
      data_bank_reg_r               <= 8'h00;
      direct_r                      <= 16'h0000;
      {xsel_r, msel_r, emu_r}       <= `CRD_RST_MODE;
      {fn_r, fv_r, fz_r, fc_r}      <= 4'h0;
      {ea_r, ptr_r, opnd_r}         <= 48'h000000000000;
      {bank_r, opl_r, wa_r}         <= 24'h000000;
      {abt_r, aborted_r, wr_pend_r} <= 3'h0;
      hrdata_r                      <= 32'h00000000;
    end else begin
      // Bus address phase
      wr_pend_r <= acc_ph & hwrite;
      wa_r      <= haddr[7:0];
      if (acc_ph && !hwrite)
        hrdata_r <= rd_mux;
      // Software register writes
      if (sw_wr) begin
        case (wa_r)
          `CRD_OFF_MODE: begin
            emu_r  <= hwdata[`CRD_MODE_E];
            msel_r <= hwdata[`CRD_MODE_M];
            xsel_r <= hwdata[`CRD_MODE_X];
          end
          `CRD_OFF_PC: begin
            pbr_r <= hwdata[23:16];
            pc_r  <= hwdata[15:0];
          end
          `CRD_OFF_ACC:    acc_r <= hwdata[15:0];
          `CRD_OFF_IDX_X:  x_r <= hwdata[15:0];
          `CRD_OFF_IDX_Y:  y_r <= hwdata[15:0];
          `CRD_OFF_DBANK:  data_bank_reg_r <= hwdata[7:0];
          `CRD_OFF_DIRECT: direct_r <= hwdata[15:0];
          `CRD_OFF_FLAGS:  {fn_r, fv_r, fz_r, fc_r} <= hwdata[3:0];
          default:         ;
        endcase
      end
      // Aborted flag: write one clears, a new abort wins
      if (ctrl_wr && hwdata[`CRD_CTRL_ABORTED])
        aborted_r <= 1'b0;
      if (abort_ev)
        abt_r <= 1'b1;
      // Memory cycle halves
      if (busy && st_r != S_EXEC)
        ph_r <= ~ph_r;
      if (cyc_end)
        step_r <= step_r + 4'h1;
      case (st_r)
        S_IDLE: begin
          if (go) begin
            st_r       <= S_FETCH;
            step_r     <= 4'h0;
            pc_start_r <= pc_r;
            abt_r      <= 1'b0;
            bidx_r     <= 1'b0;
          end
        end
        S_FETCH: begin
          if (cyc_end) begin
            opcode_latch_r <= mem_data_in;
            pc_r           <= pc_r + 16'h0001;
            // Next step chosen from the fetched code
            if (mem_data_in[7:6] == 2'b11)
              st_r <= S_EXEC;
            else if (mem_data_in[2:0] == `CRD_AM_VEC) begin
              ea_r   <= `CRD_VEC_ADDR;
              bank_r <= 8'h00;
              st_r   <= S_DAT;
            end else if (mem_data_in[2:0] == `CRD_AM_IMM)
              st_r <= S_DAT;
            else
              st_r <= S_OPL;
          end
        end
        S_OPL: begin
          if (cyc_end) begin
            opl_r <= mem_data_in;
            pc_r  <= pc_r + 16'h0001;
            case (am)
              `CRD_AM_DIR: begin
                ea_r   <= dsum;
                bank_r <= 8'h00;
                st_r   <= S_DAT;
              end
              `CRD_AM_DIRXI: begin
                ptr_r <= dsum + xv;
                st_r  <= S_PTRL;
              end
              `CRD_AM_DIRIY: begin
                ptr_r <= dsum;
                st_r  <= S_PTRL;
              end
              default: st_r <= S_OPH;
            endcase
          end
        end
        S_OPH: begin
          if (cyc_end) begin
            pc_r   <= pc_r + 16'h0001;
            bank_r <= data_bank_reg_r;
            // Base fetched, index added before the data cycle
            if (am == `CRD_AM_ABSX)
              ea_r <= {mem_data_in, opl_r} + xv;
            else if (am == `CRD_AM_ABSY)
              ea_r <= {mem_data_in, opl_r} + yv;
            else
              ea_r <= {mem_data_in, opl_r};
            st_r <= S_DAT;
          end
        end
        S_PTRL: begin
          if (cyc_end) begin
            opl_r <= mem_data_in;
            ptr_r <= ptr_r + 16'h0001;
            st_r  <= S_PTRH;
          end
        end
        S_PTRH: begin
          if (cyc_end) begin
            bank_r <= data_bank_reg_r;
            if (am == `CRD_AM_DIRIY)
              ea_r <= {mem_data_in, opl_r} + yv;
            else
              ea_r <= {mem_data_in, opl_r};
            st_r <= S_DAT;
          end
        end
        S_DAT: begin
          if (cyc_end) begin
            if (am == `CRD_AM_IMM)
              pc_r <= pc_r + 16'h0001;
            if (bidx_r)
              opnd_r[15:8] <= mem_data_in;
            else
              opnd_r <= {8'h00, mem_data_in};
            // A 16-bit value takes two memory cycles
            if (wide && !bidx_r)
              bidx_r <= 1'b1;
            else
              st_r <= S_EXEC;
          end
        end
        S_EXEC: begin
          st_r   <= S_IDLE;
          bidx_r <= 1'b0;
          // Commit only when no abort was seen in this instruction
          if (abt_r || abort_ev) begin
            pc_r      <= pc_start_r;
            aborted_r <= 1'b1;
          end else begin
            case (op)
              `CRD_OP_LDA, `CRD_OP_ADC, `CRD_OP_AND:
                acc_r <= wide ? res : {acc_r[15:8], res[7:0]};
              `CRD_OP_SWP: acc_r <= res;
              `CRD_OP_LDX: x_r <= wide ? res : {8'h00, res[7:0]};
              `CRD_OP_LDY: y_r <= wide ? res : {8'h00, res[7:0]};
              default:     acc_r <= acc_r;
            endcase
            if (op != `CRD_OP_STA && op != `CRD_OP_NOP) begin
              fn_r <= res_n;
              fz_r <= res_z;
              fc_r <= res_c;
              fv_r <= res_v;
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase
      // Narrow index mode clears the high bytes
      if (x_eff) begin
        x_r[15:8] <= 8'h00;
        y_r[15:8] <= 8'h00;
      end
    end
  end

endmodule

// ### tb/crd_core_properties.sv
// Concurrent checks on the memory-bus ports of the datapath core.
// Bound to crd_core from the testbench top; sees the core's ports only.
`timescale 1ns/1ps
`include "crd_map.vh"
module crd_core_properties (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Memory bus
  input wire logic [15:0] mem_addr,
  input wire logic        mem_data_oe,
  input wire logic        mem_rwb,
  input wire logic        valid_data_addr_out,
  input wire logic        valid_program_addr_out,
  input wire logic        vector_pull_out_n,
  input wire logic        emulation_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // Cycle framing and segment flags
  // ----------------------------------------
  AST_SEG_EXCL: assert property (!(valid_data_addr_out && valid_program_addr_out))
    else $error("data and program valid high together");
  AST_WRITE_IS_DATA: assert property (!mem_rwb |-> valid_data_addr_out)
    else $error("write cycle without data valid");
  // Bank byte only in half 0 of a read, lines released in half 1
  AST_READ_BANK_HALF: assert property ($rose(mem_data_oe) && mem_rwb |=> !mem_data_oe)
    else $error("read cycle kept data lines driven");
  AST_STORE_HALVES: assert property ($fell(mem_rwb) |-> (mem_data_oe && !mem_rwb) [*2])
    else $error("store cycle not driven for both halves");
  AST_OE_IN_CYCLE: assert property (mem_data_oe |->
    valid_data_addr_out || valid_program_addr_out)
    else $error("data lines driven outside a bus cycle");
  // Address must stand across the half edge or the bank latch sees a torn value
  AST_ADDR_STANDS: assert property ($rose(mem_data_oe) |=>
    $stable(mem_addr) && $stable(mem_rwb) && $stable(valid_data_addr_out))
    else $error("address changed between halves");
  // ----------------------------------------
  // Vector pull and mode
  // ----------------------------------------
  AST_VPULL_ADDR: assert property (!vector_pull_out_n |-> (mem_addr & 16'hFFFE) == `CRD_VEC_ADDR
    && valid_data_addr_out && mem_rwb)
    else $error("vector pull outside vector read");
  AST_VPULL_HOLD: assert property ($fell(vector_pull_out_n) |=> !vector_pull_out_n)
    else $error("vector pull shorter than one memory cycle");
  AST_EMU_AFTER_RESET: assert property ($rose(hresetn) |-> emulation_out)
    else $error("emulation flag clear after reset");
endmodule

// ### tb/crd_mem_model.sv
// External memory on the multiplexed bank/data bus, 64 KiB, no wait states.
// The testbench resolves the shared wire and feeds it back as bus_wire.
`timescale 1ns/1ps
module crd_mem_model (
  // Clock
  input wire logic        hclk,
  // Bus from the core
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  bus_wire,
  input wire logic        mem_data_oe,
  input wire logic        mem_rwb,
  input wire logic        dvalid,
  input wire logic        pvalid,
  // Answer to the wire
  output logic [7:0]      mem_drive,
  output logic            mem_drive_en,
  output logic [7:0]      bank_seen
);
  logic [7:0] mem [0:65535];
  // Answer only in the half where the core has let go of the lines
  assign mem_drive_en = mem_rwb && !mem_data_oe && (dvalid || pvalid);
  assign mem_drive    = mem[mem_addr];
  // Bank latch and store; the later half-1 write overwrites the bank byte
  always @(posedge hclk) begin
    if (mem_data_oe && mem_rwb && dvalid) begin
      bank_seen <= bus_wire;
    end
    if (mem_data_oe && !mem_rwb) begin
      mem[mem_addr] <= bus_wire;
    end
  end
endmodule

// ### tb/tb.sv
// Self-checking bench for crd_core: AHB-Lite register tasks, memory model,
// instruction runs checked through register reads.
`timescale 1ns/1ps
module tb;
  logic        hclk, hresetn, hsel, hwrite, abort_n;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  last_wire;
  wire  [31:0] hrdata;
  wire  [15:0] mem_addr;
  wire  [7:0]  mem_out, mem_wire, mem_drive, bank_seen;
  wire         hreadyout, hresp, oe, rwb, dvalid, pvalid, vpull_n, emu, mem_en;
  int          bad_count, n_compared;
  // ----------------------------------------
  // Wire resolution, undriven lines flip each cycle
  // ----------------------------------------
  assign mem_wire = oe ? mem_out : (mem_en ? mem_drive : ~last_wire);
  always @(posedge hclk) last_wire <= mem_wire;
  crd_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_addr(mem_addr),
    .mem_data_out(mem_out), .mem_data_oe(oe), .mem_data_in(mem_wire), .mem_rwb(rwb),
    .valid_data_addr_out(dvalid), .valid_program_addr_out(pvalid), .vector_pull_out_n(vpull_n),
    .abort_input_n(abort_n), .emulation_out(emu));
  crd_mem_model i_mem (.hclk(hclk), .mem_addr(mem_addr), .bus_wire(mem_wire),
    .mem_data_oe(oe), .mem_rwb(rwb), .dvalid(dvalid), .pvalid(pvalid), .mem_drive(mem_drive),
    .mem_drive_en(mem_en), .bank_seen(bank_seen));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  // One single AHB transfer; waits on hready, bench watchdog bounds it
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask
  // Place three bytes at 0x0200, start there and poll busy
  task automatic run(input logic [7:0] b0, b1, b2, input logic ab);
    int n;
    i_mem.mem[16'h0200] = b0;
    i_mem.mem[16'h0201] = b1;
    i_mem.mem[16'h0202] = b2;
    wr(8'h08, 32'h0000_0200);
    wr(8'h00, 32'h1);
    if (ab) abort_n <= 1'b0;
    n = 0;
    do begin
      ahb(1'b0, 8'h00, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
    abort_n <= 1'b1;
    chk("busy", 32'h0, {31'h0, rd[0]});
  endtask
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Watchdog, well beyond the few hundred cycles the tests take
  // ----------------------------------------
  initial begin
    #300000;
    bad_count++;
    end_of_test;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, last_wire} = '0;
    hsize = 3'h2;
    abort_n = 1'b1;
    hresetn = 1'b0;
    bad_count = 0;
    n_compared = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("mode", 8'h04, 32'h7);
    rdc("dbank", 8'h18, 32'h0);
    rdc("direct", 8'h1C, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    chk("emulation", 32'h1, {31'h0, emu});
    wr(8'h04, 32'h0);
    // Mode lands on the task's last edge; look once it has settled
    @(negedge hclk);
    chk("emulation", 32'h0, {31'h0, emu});
    run(8'h00, 8'h34, 8'h12, 1'b0);
    rdc("acc16", 8'h0C, 32'h1234);
    // 8-bit accumulator keeps its upper byte, swap exchanges
    wr(8'h04, 32'h2);
    run(8'h00, 8'hAB, 8'h00, 1'b0);
    rdc("acc8", 8'h0C, 32'h12AB);
    run(8'hC0, 8'h00, 8'h00, 1'b0);
    rdc("swap", 8'h0C, 32'hAB12);
    ahb(1'b0, 8'h24, 32'h0);
    chk("opstat", 32'h1C0, {20'h0, rd[11:0]});
    run(8'h00, 8'h7F, 8'h00, 1'b0);
    run(8'h40, 8'h01, 8'h00, 1'b0);
    rdc("adc", 8'h0C, 32'hAB80);
    rdc("flags", 8'h20, 32'hC);
    // Direct sum wraps in 16 bits and ignores the data bank
    wr(8'h1C, 32'hFFF0);
    wr(8'h18, 32'h55);
    i_mem.mem[16'h0010] = 8'h5A;
    run(8'h01, 8'h20, 8'h00, 1'b0);
    rdc("direct", 8'h0C, 32'hAB5A);
    chk("dir bank", 32'h0, {24'h0, bank_seen});
    i_mem.mem[16'h3000] = 8'h3C;
    run(8'h02, 8'h00, 8'h30, 1'b0);
    rdc("abs", 8'h0C, 32'hAB3C);
    chk("abs bank", 32'h55, {24'h0, bank_seen});
    // 8-bit index registers and the indexed modes
    wr(8'h04, 32'h6);
    wr(8'h10, 32'h1234);
    rdc("x8", 8'h10, 32'h34);
    i_mem.mem[16'h3034] = 8'h4D;
    run(8'h03, 8'h00, 8'h30, 1'b0);
    rdc("absx", 8'h0C, 32'hAB4D);
    wr(8'h1C, 32'h0);
    {i_mem.mem[16'h0045], i_mem.mem[16'h0044], i_mem.mem[16'h4000]} = 24'h40_00_61;
    run(8'h05, 8'h10, 8'h00, 1'b0);
    rdc("preidx", 8'h0C, 32'hAB61);
    wr(8'h14, 32'h2);
    {i_mem.mem[16'h0011], i_mem.mem[16'h0010], i_mem.mem[16'h5002]} = 24'h50_00_72;
    run(8'h06, 8'h10, 8'h00, 1'b0);
    rdc("postidx", 8'h0C, 32'hAB72);
    run(8'h22, 8'h00, 8'h31, 1'b0);
    chk("store", 32'h72, {24'h0, i_mem.mem[16'h3100]});
    i_mem.mem[16'hFFF0] = 8'h83;
    run(8'h07, 8'h00, 8'h00, 1'b0);
    rdc("vector", 8'h0C, 32'hAB83);
    // Abort mid-instruction leaves the accumulator alone
    run(8'h00, 8'h11, 8'h00, 1'b1);
    rdc("abort acc", 8'h0C, 32'hAB83);
    rdc("aborted", 8'h00, 32'h2);
    wr(8'h00, 32'h2);
    rdc("abort clr", 8'h00, 32'h0);
    // 16-bit data, low byte first
    wr(8'h04, 32'h0);
    {i_mem.mem[16'h3201], i_mem.mem[16'h3200]} = 16'hBEEF;
    run(8'h02, 8'h00, 8'h32, 1'b0);
    rdc("acc16 abs", 8'h0C, 32'hBEEF);
    // Fetch, two operands and two data bytes: five memory cycles
    rdc("steps16", 8'h24, 32'h502);
    wr(8'h04, 32'h1);
    rdc("emu mode", 8'h04, 32'h7);
    chk("emulation", 32'h1, {31'h0, emu});
    chk("hresp", 32'h0, {31'h0, hresp});
    end_of_test;
  end
endmodule
bind crd_core crd_core_properties i_props (.hclk, .hresetn, .mem_addr, .mem_data_oe,
  .mem_rwb, .valid_data_addr_out, .valid_program_addr_out, .vector_pull_out_n,
  .emulation_out);
